/* File: include/swrd_pkg.sv */
// Package for the serial word register decoder: word layout, codes, reset values.
// Assumes a single 250 MHz clock domain in the user of this package.

package swrd_pkg;

  // ----------------------------------------------------------------
  // Frame lengths and field widths
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 24;      // Plain frame length
  localparam int PEC_WORD_BITS = 32;  // Frame length with check code appended
  localparam int CHECK_BITS = 8;      // Trailing check code width
  localparam int PAYLOAD_BITS = 16;   // Data field width
  localparam int NUM_CHAN = 4;        // Channels A to D
  localparam int CNT_BITS = 6;        // Bit counter width, saturates
  localparam logic [5:0] CNT_MAX = 6'h3F;

  // ----------------------------------------------------------------
  // Register-select codes (word bits 20:18)
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_CODE = 3'h0;
  localparam logic [2:0] SEL_UNDEF = 3'h1;
  localparam logic [2:0] SEL_GAIN = 3'h2;
  localparam logic [2:0] SEL_GAIN_ALL = 3'h3;
  localparam logic [2:0] SEL_OFFS = 3'h4;
  localparam logic [2:0] SEL_OFFS_ALL = 3'h5;
  localparam logic [2:0] SEL_CLEAR = 3'h6;
  localparam logic [2:0] SEL_CTRL = 3'h7;

  // ----------------------------------------------------------------
  // Per-channel register kinds inside the register memory
  // ----------------------------------------------------------------
  localparam logic [1:0] KIND_CODE = 2'h0;
  localparam logic [1:0] KIND_GAIN = 2'h1;
  localparam logic [1:0] KIND_OFFS = 2'h2;
  localparam logic [1:0] KIND_CLEAR = 2'h3;

  // ----------------------------------------------------------------
  // Control-group selects (payload bits 15:13)
  // ----------------------------------------------------------------
  localparam logic [2:0] CTRL_SLEW = 3'h0;
  localparam logic [2:0] CTRL_MAIN = 3'h1;
  localparam logic [2:0] CTRL_CHAN = 3'h2;
  localparam logic [2:0] CTRL_SUPPLY = 3'h3;
  localparam logic [2:0] CTRL_SOFT = 3'h4;

  // ----------------------------------------------------------------
  // Reset values of the per-channel registers
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_CODE = 16'h0000;
  localparam logic [15:0] RST_GAIN = 16'hFFFF;
  localparam logic [15:0] RST_OFFS = 16'h8000;
  localparam logic [15:0] RST_CLEAR = 16'h0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rw;              // 1 = read, 0 = write
    logic [1:0] dev_addr;  // target_device_sel_hi, target_device_sel_lo
    logic [2:0] reg_sel;   // reg_select_b2..b0
    logic [1:0] chan;      // channel_select_hi, channel_select_lo
    logic [15:0] payload;  // Data field
  } swrd_word_t;

  typedef struct packed {
    logic [2:0] sel;       // control_reg_select
    logic [1:0] chan;      // Channel for per-channel control registers
    logic [12:0] data;     // Control data bits
  } swrd_ctrl_t;

endpackage

/* File: logic/swrd_decoder.sv */
// Serial word register decoder: frames, checks and dispatches host words.
// Assumes serial pins are asynchronous to i_mclk and far slower than it.
//
// Functional notes
// - Plain frame is exactly 24 bits.
// - Checked frame is 32 bits, code last.
// - Word fields: rw, address, select, channel, payload.
// - Output-code write takes bits 15 to 0.
// - Act only when address equals strap pins.
// - Select 000 writes selected channel code.
// - Select 010 gain one, 011 all.
// - Select 100 offset one, 101 all.
// - Select 110 writes selected clear code.
// - Select 111 passes to control decode.
// - Channel bits ignored for all-channel writes.
// - Payload bits 15:13 pick control register.
`timescale 1ns/100ps

module swrd_decoder #(
  parameter int NUM_CHAN = swrd_pkg::NUM_CHAN
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_sclk,
  input wire logic i_sync_n,
  input wire logic i_sdin,
  input wire logic i_strap_pin_hi,
  input wire logic i_strap_pin_lo,
  input wire logic i_pec_en,
  input wire logic [1:0] i_rd_chan,
  input wire logic [1:0] i_rd_kind,
  output logic [15:0] o_rd_data,
  output swrd_pkg::swrd_word_t o_word,
  output logic o_word_valid,
  output logic [7:0] o_check_code,
  output swrd_pkg::swrd_ctrl_t o_ctrl,
  output logic o_ctrl_wr,
  output logic o_read_req,
  output logic o_discard
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pin_m_q;   // First stage, read only by second stage
  logic [5:0] pin_s_q;   // Second stage, safe to use
  logic sclk_d1_q;       // Delayed clock for edge detection
  logic sync_d1_q;       // Delayed frame for edge detection

  // Both stages for all pins so data stays aligned with clock edges
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      pin_m_q <= 6'h3F;
      pin_s_q <= 6'h3F;
      sclk_d1_q <= 1'b1;
      sync_d1_q <= 1'b1;
    end else begin
      pin_m_q <= {i_sclk, i_sync_n, i_sdin, i_strap_pin_hi, i_strap_pin_lo, i_pec_en};
      pin_s_q <= pin_m_q;
      sclk_d1_q <= pin_s_q[5];
      sync_d1_q <= pin_s_q[4];
    end
  end

  logic sclk_s, sync_s, sdin_s, pec_s;
  logic [1:0] strap_s;
  assign sclk_s = pin_s_q[5];
  assign sync_s = pin_s_q[4];
  assign sdin_s = pin_s_q[3];
  assign strap_s = pin_s_q[2:1];
  assign pec_s = pin_s_q[0];

  logic sclk_fall, frame_start, frame_end;
  // Data is taken on falling serial clock edges
  assign sclk_fall = sclk_d1_q && !sclk_s;
  assign frame_start = sync_d1_q && !sync_s;
  assign frame_end = !sync_d1_q && sync_s;

  // ----------------------------------------------------------------
  // Frame state machine
  // ----------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_SHIFT} swrd_state_t;
  swrd_state_t state_q;

  // Shifting runs only while the frame is low
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (frame_start) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (frame_end) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Shift register and bit counter
  // ----------------------------------------------------------------
  logic [31:0] shift_q;                   // Last 32 bits, newest at bit 0
  logic [swrd_pkg::CNT_BITS-1:0] cnt_q;   // Saturating bit count

  // Counter saturates so overlong frames never wrap back to a legal length
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      shift_q <= 32'h0000_0000;
      cnt_q <= '0;
    end else if (frame_start) begin
      cnt_q <= '0;
    end else if (state_q == ST_SHIFT && sclk_fall) begin
      shift_q <= {shift_q[30:0], sdin_s};
      if (cnt_q != swrd_pkg::CNT_MAX) begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Word decode, evaluated in the frame-end cycle
  // ----------------------------------------------------------------
  swrd_pkg::swrd_word_t word;
  logic len_ok, addr_ok, take;
  logic [NUM_CHAN-1:0] chan_hot;

  // Checked frames keep the normal layout ahead of the code
  assign word = pec_s ? shift_q[31:8] : shift_q[23:0];
  // Exactly one full word per frame, else only a discard pulse
  assign len_ok = pec_s ? (cnt_q == 6'(swrd_pkg::PEC_WORD_BITS))
                        : (cnt_q == 6'(swrd_pkg::WORD_BITS));
  // Device address must equal the straps
  assign addr_ok = (word.dev_addr == strap_s);
  assign take = frame_end && (state_q == ST_SHIFT) && len_ok && addr_ok;
  // Channel 00..11 map to A..D as one-hot
  assign chan_hot = NUM_CHAN'(1) << word.chan;

  logic [NUM_CHAN-1:0] wr_mask_d;
  logic [1:0] wr_kind_d;
  logic ctrl_wr_d;

  // Select decode; reads never alter registers
  always_comb begin
    wr_mask_d = '0;
    wr_kind_d = swrd_pkg::KIND_CODE;
    ctrl_wr_d = 1'b0;
    if (take && !word.rw) begin
      case (word.reg_sel)
        swrd_pkg::SEL_CODE: begin
          wr_mask_d = chan_hot;
        end
        swrd_pkg::SEL_GAIN: begin
          wr_mask_d = chan_hot;
          wr_kind_d = swrd_pkg::KIND_GAIN;
        end
        swrd_pkg::SEL_GAIN_ALL: begin
          wr_mask_d = '1;
          wr_kind_d = swrd_pkg::KIND_GAIN;
        end
        swrd_pkg::SEL_OFFS: begin
          wr_mask_d = chan_hot;
          wr_kind_d = swrd_pkg::KIND_OFFS;
        end
        swrd_pkg::SEL_OFFS_ALL: begin
          wr_mask_d = '1;
          wr_kind_d = swrd_pkg::KIND_OFFS;
        end
        swrd_pkg::SEL_CLEAR: begin
          wr_mask_d = chan_hot;
          wr_kind_d = swrd_pkg::KIND_CLEAR;
        end
        swrd_pkg::SEL_CTRL: begin
          ctrl_wr_d = 1'b1;
        end
        default: begin
          // Undefined select falls here and changes nothing
          wr_mask_d = '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Write pipeline into the register memory
  // ----------------------------------------------------------------
  logic [NUM_CHAN-1:0] wr_mask_q;
  logic [1:0] wr_kind_q;
  logic [15:0] wr_data_q;

  // Full 16-bit payload is the data for every per-channel write
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      wr_mask_q <= '0;
      wr_kind_q <= swrd_pkg::KIND_CODE;
      wr_data_q <= 16'h0000;
    end else begin
      wr_mask_q <= wr_mask_d;
      wr_kind_q <= wr_kind_d;
      if (|wr_mask_d) begin
        wr_data_q <= word.payload;
      end
    end
  end

  swrd_regmem #(
    .DATA_W(swrd_pkg::PAYLOAD_BITS),
    .NUM_CHAN(NUM_CHAN)
  ) u_regmem (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_wr_mask(wr_mask_q),
    .i_wr_kind(wr_kind_q),
    .i_wr_data(wr_data_q),
    .i_rd_chan(i_rd_chan),
    .i_rd_kind(i_rd_kind),
    .o_rd_data(o_rd_data)
  );

  // ----------------------------------------------------------------
  // Word, control and status outputs
  // ----------------------------------------------------------------
  // Accepted word and its check code are held until the next one
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_word <= '0;
      o_check_code <= 8'h00;
      o_word_valid <= 1'b0;
    end else begin
      o_word_valid <= take;
      if (take) begin
        o_word <= word;
        o_check_code <= pec_s ? shift_q[7:0] : 8'h00;
      end
    end
  end

  // Control group: payload top bits name the register
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_ctrl <= '0;
      o_ctrl_wr <= 1'b0;
    end else begin
      o_ctrl_wr <= ctrl_wr_d;
      if (ctrl_wr_d) begin
        o_ctrl <= {word.payload[15:13], word.chan, word.payload[12:0]};
      end
    end
  end

  // Reads are flagged; undefined-select writes and short, long or foreign words discarded
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_read_req <= 1'b0;
      o_discard <= 1'b0;
    end else begin
      o_read_req <= take && word.rw;
      o_discard <= frame_end && (state_q == ST_SHIFT)
                   && (!take || (!word.rw && word.reg_sel == swrd_pkg::SEL_UNDEF));
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_accept_write(logic [2:0] sel);
    take && !word.rw && word.reg_sel == sel;
  endsequence

  a_plain_len_exact: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    frame_end && !pec_s && cnt_q != 6'(swrd_pkg::WORD_BITS) |=> wr_mask_q == '0 && !o_ctrl_wr && !o_word_valid)
    else $error("plain frame of wrong length was acted on");

  a_pec_code_kept: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    take && pec_s |=> o_check_code == $past(shift_q[7:0]) && o_word == $past(shift_q[31:8]))
    else $error("checked frame split wrongly");

  a_field_layout: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    take && !pec_s |=> o_word_valid && o_word.reg_sel == $past(shift_q[20:18]))
    else $error("word fields misplaced");

  a_code_payload: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    s_accept_write(swrd_pkg::SEL_CODE) ##1 1'b1 |-> wr_data_q == $past(word.payload)
      ##2 (i_rd_kind != swrd_pkg::KIND_CODE || i_rd_chan != $past(word.chan, 3)
           || o_rd_data == $past(word.payload, 3)))
    else $error("output code not written from payload");

  a_addr_match: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    frame_end && word.dev_addr != strap_s |=> wr_mask_q == '0 && !o_ctrl_wr && !o_read_req)
    else $error("foreign device address acted on");

  a_code_one_chan: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    s_accept_write(swrd_pkg::SEL_CODE) |=> wr_mask_q == NUM_CHAN'(1) << $past(word.chan)
      && wr_kind_q == swrd_pkg::KIND_CODE)
    else $error("code write hit wrong channel");

  a_gain_all: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    s_accept_write(swrd_pkg::SEL_GAIN_ALL) |=> &wr_mask_q && wr_kind_q == swrd_pkg::KIND_GAIN)
    else $error("gain broadcast missed a channel");

  a_offs_all: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    s_accept_write(swrd_pkg::SEL_OFFS_ALL) |=> &wr_mask_q && wr_kind_q == swrd_pkg::KIND_OFFS)
    else $error("offset broadcast missed a channel");

  a_clear_one: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    s_accept_write(swrd_pkg::SEL_CLEAR) |=> $onehot(wr_mask_q) && wr_kind_q == swrd_pkg::KIND_CLEAR)
    else $error("clear code write misrouted");

  a_ctrl_select: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    s_accept_write(swrd_pkg::SEL_CTRL) |=> o_ctrl_wr && wr_mask_q == '0
      && o_ctrl.sel == $past(word.payload[15:13]))
    else $error("control group write misdecoded");

  a_undef_dropped: assert property (@(posedge i_mclk) disable iff (!i_resetn)
    s_accept_write(swrd_pkg::SEL_UNDEF) |=> wr_mask_q == '0 && !o_ctrl_wr && o_discard)
    else $error("undefined select altered state");

endmodule

/* File: logic/swrd_regmem.sv */
// Per-channel register memory: output code, gain, offset and clear code.
// Assumes writes and reads come from logic on the same clock.
`timescale 1ns/100ps

module swrd_regmem #(
  parameter int DATA_W = 16,
  parameter int NUM_CHAN = 4
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [NUM_CHAN-1:0] i_wr_mask,
  input wire logic [1:0] i_wr_kind,
  input wire logic [DATA_W-1:0] i_wr_data,
  input wire logic [1:0] i_rd_chan,
  input wire logic [1:0] i_rd_kind,
  output logic [DATA_W-1:0] o_rd_data
);

  // ----------------------------------------------------------------
  // Storage, one bank of four registers per channel
  // ----------------------------------------------------------------
  // Unpacked so each channel's process owns its own elements
  logic [DATA_W-1:0] bank_q [NUM_CHAN][4]; // Channel, kind, word

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      // Mask lets one write land on all channels in the same cycle
      always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
          bank_q[ch][0] <= DATA_W'(swrd_pkg::RST_CODE);
          bank_q[ch][1] <= DATA_W'(swrd_pkg::RST_GAIN);
          bank_q[ch][2] <= DATA_W'(swrd_pkg::RST_OFFS);
          bank_q[ch][3] <= DATA_W'(swrd_pkg::RST_CLEAR);
        end else if (i_wr_mask[ch]) begin
          bank_q[ch][i_wr_kind] <= i_wr_data;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registered read port
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= bank_q[i_rd_chan][i_rd_kind];
    end
  end

endmodule

/* File: test/swrd_host_model.sv */
// Host controller model: shifts words into the decoder over the serial pins.
// Assumes the caller passes the frame bits right-aligned and a bit count.
`timescale 1ns/100ps

module swrd_host_model (
  output logic o_sclk,
  output logic o_sync_n,
  output logic o_sdin
);
  // ----------------------------------------------------------------
  // Idle pin levels
  // ----------------------------------------------------------------
  // Link clock stands high outside frames
  initial begin
    o_sclk = 1'b1;
    o_sync_n = 1'b1;
    o_sdin = 1'b0;
  end

  // ----------------------------------------------------------------
  // One frame, MSB first, 32 ns link clock
  // ----------------------------------------------------------------
  // Data set while sclk is high, taken on the falling edge
  task automatic send_frame(input logic [31:0] bits, input int nbits);
    #16 o_sync_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      o_sdin = bits[i];
      #16 o_sclk = 1'b0;
      #16 o_sclk = 1'b1;
    end
    #16 o_sync_n = 1'b1;
    // Released line shows the inverse, never a stale bit
    o_sdin = ~o_sdin;
    #40;
  endtask
endmodule

/* File: test/tb_top.sv */
// Testbench for the serial word decoder: frames in, readback and pulses out.
// Assumes the host model drives the serial pins and straps are static per test.
`timescale 1ns/100ps

module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_strap_pin_hi = 1'b0;
  logic i_strap_pin_lo = 1'b0;
  logic i_pec_en = 1'b0;
  logic [1:0] i_rd_chan = 2'h0;
  logic [1:0] i_rd_kind = 2'h0;
  logic sclk, sync_n, sdin;
  logic [15:0] o_rd_data;
  logic [7:0] o_check_code;
  swrd_pkg::swrd_word_t o_word;
  swrd_pkg::swrd_ctrl_t o_ctrl;
  logic o_word_valid, o_ctrl_wr, o_read_req, o_discard;
  logic [15:0] exp_reg [4][4]; // Expected registers, channel then kind
  int miscompares = 0;
  int checks_done = 0;
  int n_val = 0, n_disc = 0, n_ctrl = 0, n_read = 0, cycles = 0;

  always #2 i_mclk = ~i_mclk;

  swrd_host_model swrd_host_model_inst (.o_sclk(sclk), .o_sync_n(sync_n), .o_sdin(sdin));

  swrd_decoder swrd_decoder_inst (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_sclk(sclk), .i_sync_n(sync_n), .i_sdin(sdin),
    .i_strap_pin_hi(i_strap_pin_hi), .i_strap_pin_lo(i_strap_pin_lo), .i_pec_en(i_pec_en),
    .i_rd_chan(i_rd_chan), .i_rd_kind(i_rd_kind), .o_rd_data(o_rd_data), .o_word(o_word),
    .o_word_valid(o_word_valid), .o_check_code(o_check_code), .o_ctrl(o_ctrl), .o_ctrl_wr(o_ctrl_wr),
    .o_read_req(o_read_req), .o_discard(o_discard)
  );

  // ----------------------------------------------------------------
  // Pulse counters and hang guard
  // ----------------------------------------------------------------
  // Counting pulses avoids racing the sync jitter of one cycle
  always @(posedge i_mclk) begin
    n_val += (o_word_valid === 1'b1);
    n_disc += (o_discard === 1'b1);
    n_ctrl += (o_ctrl_wr === 1'b1);
    n_read += (o_read_req === 1'b1);
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
    checks_done++;
    if (seen !== expv) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, expv, seen);
    end
  endtask

  // Compare all sixteen registers through the readback port
  task automatic chk_all();
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge i_mclk);
        #1;
        i_rd_chan = c[1:0];
        i_rd_kind = k[1:0];
        repeat (2) @(posedge i_mclk);
        #1;
        check("register", {16'h0000, o_rd_data}, {16'h0000, exp_reg[c][k]});
      end
    end
  endtask

  // Send one frame, then compare pulses, outputs and registers
  task automatic xfer(input logic [23:0] w, input int nbits);
    int v0, d0, c0, r0;
    logic ok, drop;
    v0 = n_val;
    d0 = n_disc;
    c0 = n_ctrl;
    r0 = n_read;
    ok = (nbits == (i_pec_en ? 32 : 24)) && (w[22:21] === {i_strap_pin_hi, i_strap_pin_lo});
    drop = !ok || (w[20:18] == swrd_pkg::SEL_UNDEF && !w[23]);
    swrd_host_model_inst.send_frame(i_pec_en ? {w, 8'hA5} : {8'h00, w}, nbits);
    repeat (4) @(posedge i_mclk);
    check("discard", n_disc - d0, {31'h0, drop});
    if (!drop && w[23]) begin
      check("read pulse", n_read - r0, 32'h1);
    end else if (!drop && w[20:18] == swrd_pkg::SEL_CTRL) begin
      check("ctrl pulse", n_ctrl - c0, 32'h1);
      check("ctrl", {14'h0, o_ctrl}, {14'h0, w[15:13], w[17:16], w[12:0]});
    end else if (!drop) begin
      check("valid", n_val - v0, 32'h1);
      check("word", {8'h00, o_word}, {8'h00, w});
      check("check code", {24'h0, o_check_code}, {24'h0, i_pec_en ? 8'hA5 : 8'h00});
      for (int c = 0; c < 4; c++) begin
        case (w[20:18])
          swrd_pkg::SEL_CODE: if (c == w[17:16]) exp_reg[c][0] = w[15:0];
          swrd_pkg::SEL_GAIN: if (c == w[17:16]) exp_reg[c][1] = w[15:0];
          swrd_pkg::SEL_GAIN_ALL: exp_reg[c][1] = w[15:0];
          swrd_pkg::SEL_OFFS: if (c == w[17:16]) exp_reg[c][2] = w[15:0];
          swrd_pkg::SEL_OFFS_ALL: exp_reg[c][2] = w[15:0];
          swrd_pkg::SEL_CLEAR: if (c == w[17:16]) exp_reg[c][3] = w[15:0];
          default: ;
        endcase
      end
    end
    chk_all();
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    for (int c = 0; c < 4; c++) begin
      exp_reg[c][0] = swrd_pkg::RST_CODE;
      exp_reg[c][1] = swrd_pkg::RST_GAIN;
      exp_reg[c][2] = swrd_pkg::RST_OFFS;
      exp_reg[c][3] = swrd_pkg::RST_CLEAR;
    end
    repeat (8) @(posedge i_mclk);
    #1 i_resetn = 1'b1;
    repeat (4) @(posedge i_mclk);
    chk_all();
    $display("test reset values finished");
    // Each single-channel kind on every channel
    for (int c = 0; c < 4; c++) begin
      for (int s = 0; s < 8; s += 2) begin
        xfer({3'h0, s[2:0], c[1:0], c[3:0], s[3:0], 8'hC3}, 24);
      end
    end
    $display("test single channel finished");
    xfer({3'h0, swrd_pkg::SEL_GAIN_ALL, 2'h2, 16'h1234}, 24);
    xfer({3'h0, swrd_pkg::SEL_OFFS_ALL, 2'h1, 16'h4321}, 24);
    $display("test all channels finished");
    // Every strap setting, matching and mismatching address
    for (int a = 0; a < 4; a++) begin
      @(posedge i_mclk);
      #1 {i_strap_pin_hi, i_strap_pin_lo} = a[1:0];
      repeat (4) @(posedge i_mclk);
      xfer({1'b0, a[1:0], swrd_pkg::SEL_CODE, a[1:0], 12'hABC, a[3:0]}, 24);
      xfer({1'b0, a[1:0] ^ 2'h1, swrd_pkg::SEL_CLEAR, 2'h0, 16'hDEAD}, 24);
    end
    @(posedge i_mclk);
    #1 {i_strap_pin_hi, i_strap_pin_lo} = 2'h0;
    repeat (4) @(posedge i_mclk);
    $display("test address match finished");
    xfer({3'h0, swrd_pkg::SEL_UNDEF, 2'h3, 16'h5555}, 24);
    xfer({3'h4, swrd_pkg::SEL_CODE, 2'h1, 16'h7777}, 24);
    xfer({3'h0, swrd_pkg::SEL_CODE, 2'h2, 16'h9999}, 23);
    xfer({3'h0, swrd_pkg::SEL_CODE, 2'h2, 16'h9999}, 25);
    $display("test refusals finished");
    for (int k = 0; k < 5; k++) begin
      xfer({3'h0, swrd_pkg::SEL_CTRL, k[1:0], k[2:0], 13'h0A5A ^ k[12:0]}, 24);
    end
    $display("test control group finished");
    @(posedge i_mclk);
    #1 i_pec_en = 1'b1;
    repeat (4) @(posedge i_mclk);
    xfer({3'h0, swrd_pkg::SEL_CODE, 2'h3, 16'h0F0F}, 32);
    xfer({3'h0, swrd_pkg::SEL_CODE, 2'h3, 16'hF0F0}, 24);
    $display("test checked frames finished");
    close_out();
  end
endmodule
